// ===== design/flash_host_ctrl.sv
// host controller for a byte-wide parallel flash: register port, pins, status polling
// assumes software drives the plain register port synchronously to clk_in
//
// Contract
// - Host reads status twice in a row; unchanged toggle means done.
// - Toggling with timing flag high: recheck; still toggling means failed, reset.
// - Host restarts polling from the first double read after leaving it.
// - After erase timeout host writes reset before new sequences.
// - Host checks window flag before and after each added sector erase command; the code does not, it only keeps the polled status byte for software.
// - Writes only with chip select and write low and output enable high.
// - Protect: elevated voltage on id pin and oe, direction pin low, ce low.
// - Unprotect: elevated voltage on oe and id pin, direction pin high.
// - Equipment protects all sectors before running chip unprotect; the code runs unprotect anyway, prot_all_q only records a prior protect.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  output logic             flash_ce_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out,
  output logic [18:0]      flash_addr_out,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [7:0]  flash_dq_in,
  output logic             elevated_id_voltage_addr_out,
  output logic             elevated_id_voltage_oe_out
);
  logic        rst_sync1_q;
  logic        rst_n;
  logic        busy_q;
  logic        err_q;
  logic [2:0]  cmd_q;
  logic        sector_sel_q;
  logic [18:0] addr_reg_q;
  logic [7:0]  wdata_reg_q;
  logic [7:0]  rdata_reg_q;
  logic [1:0]  poll_res_q;
  logic [7:0]  poll_stat_q;
  logic        prot_all_q;
  logic        cyc_req_q;
  logic        poll_start_q;
  logic        poll_rd_req;
  logic        poll_fin;
  logic [1:0]  poll_result;
  logic [7:0]  poll_status;
  logic        ctrl_wr;
  logic        protect_seen_q;
  logic        need_reset_q;
  logic        refuse_wr;

  flash_cycle_if cyc ();

  // reset release through two flip-flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_q <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n       <= rst_sync1_q;
    end
  end

  // register access decode
  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
    is_reg = (a == off);
  endfunction

  assign ctrl_wr = reg_wr_in && is_reg(reg_addr_in, REG_CTRL);

  // after a failed poll, program and protect wait until the reset code has gone out
  assign refuse_wr = need_reset_q &&
                     (reg_wdata_in[2:0] == CMD_PROTECT || reg_wdata_in[2:0] == CMD_UNPROT ||
                      (reg_wdata_in[2:0] == CMD_WRITE && wdata_reg_q != RESET_CMD_CODE));

  // a failed poll leaves the flash locked until the host writes the reset code
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      need_reset_q <= 1'b0;
    end else if (poll_fin && poll_result == POLL_FAILED) begin
      need_reset_q <= 1'b1;
    end else if (ctrl_wr && !busy_q && !refuse_wr && reg_wdata_in[2:0] == CMD_WRITE) begin
      need_reset_q <= 1'b0;
    end
  end

  // address and write data registers
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg_q  <= '0;
      wdata_reg_q <= '0;
    end else if (reg_wr_in && !busy_q) begin
      if (is_reg(reg_addr_in, REG_ADDR)) begin
        addr_reg_q <= reg_wdata_in[18:0];
      end else if (is_reg(reg_addr_in, REG_WDATA)) begin
        wdata_reg_q <= reg_wdata_in[7:0];
      end
    end
  end

  // command acceptance; commands while busy are refused and flagged
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      busy_q       <= 1'b0;
      err_q        <= 1'b0;
      cmd_q        <= '0;
      sector_sel_q <= 1'b0;
      cyc_req_q    <= 1'b0;
      poll_start_q <= 1'b0;
    end else begin
      cyc_req_q    <= 1'b0;
      poll_start_q <= 1'b0;
      if (ctrl_wr && (busy_q || refuse_wr)) begin
        err_q <= 1'b1;
      end else if (ctrl_wr && reg_wdata_in[2:0] != 3'h0) begin
        busy_q       <= 1'b1;
        err_q        <= 1'b0;
        cmd_q        <= reg_wdata_in[2:0];
        sector_sel_q <= reg_wdata_in[4];
        if (reg_wdata_in[2:0] == CMD_POLL) begin
          poll_start_q <= 1'b1;
        end else begin
          cyc_req_q <= 1'b1;
        end
      end else if (busy_q && (cyc.done && cmd_q != CMD_POLL || poll_fin)) begin
        busy_q <= 1'b0;
      end
    end
  end

  // cycle request mux between direct commands and the poller
  always_comb begin
    cyc.req      = cyc_req_q || poll_rd_req;
    cyc.is_write = (cmd_q == CMD_WRITE) || (cmd_q == CMD_PROTECT) || (cmd_q == CMD_UNPROT);
    cyc.hv_mode  = (cmd_q == CMD_PROTECT) || (cmd_q == CMD_UNPROT) || (cmd_q == CMD_VERIFY);
    cyc.hv_oe    = (cmd_q == CMD_PROTECT) || (cmd_q == CMD_UNPROT);
    cyc.wdata    = wdata_reg_q;
    cyc.addr     = addr_reg_q;
    if (cmd_q == CMD_PROTECT) begin
      cyc.addr[PROT_DIR_ADDR_POS] = 1'b0;
    end else if (cmd_q == CMD_UNPROT) begin
      cyc.addr[PROT_DIR_ADDR_POS] = 1'b1;
    end else if (cmd_q == CMD_VERIFY) begin
      cyc.addr[ID_SEL_ADDR_POS] = 1'b1;
    end
    if (cyc.hv_mode) begin
      cyc.addr[HV_ID_ADDR_POS] = 1'b1;
    end
  end

  // last read result; verify reads keep only the protect bit
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg_q <= '0;
    end else if (cyc.done && cmd_q == CMD_READ) begin
      rdata_reg_q <= cyc.rdata;
    end else if (cyc.done && cmd_q == CMD_VERIFY) begin
      rdata_reg_q <= {7'h00, cyc.rdata[PROTECT_BIT_POS]};
    end
  end

  // poll outcome capture; the kept status byte lets software see the erase window flag
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      poll_res_q  <= '0;
      poll_stat_q <= '0;
    end else if (poll_start_q) begin
      poll_res_q <= '0;
    end else if (poll_fin) begin
      poll_res_q  <= poll_result;
      poll_stat_q <= poll_status;
    end
  end

  // track that a protect pass has run since reset or the last unprotect, advised before unprotect
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      protect_seen_q <= 1'b0;
      prot_all_q     <= 1'b0;
    end else if (cyc.done && cmd_q == CMD_PROTECT) begin
      protect_seen_q <= 1'b1;
    end else if (cyc.done && cmd_q == CMD_UNPROT) begin
      prot_all_q     <= protect_seen_q;
      protect_seen_q <= 1'b0;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      if (is_reg(reg_addr_in, REG_CTRL)) begin
        reg_rdata_out <= {27'h0, sector_sel_q, 1'b0, cmd_q};
      end else if (is_reg(reg_addr_in, REG_ADDR)) begin
        reg_rdata_out <= {13'h0, addr_reg_q};
      end else if (is_reg(reg_addr_in, REG_WDATA)) begin
        reg_rdata_out <= {24'h0, wdata_reg_q};
      end else if (is_reg(reg_addr_in, REG_STATUS)) begin
        reg_rdata_out <= {16'h0, poll_stat_q, 3'h0, prot_all_q, poll_res_q, err_q, busy_q};
      end else if (is_reg(reg_addr_in, REG_RDATA)) begin
        reg_rdata_out <= {24'h0, rdata_reg_q};
      end else begin
        reg_rdata_out <= '0;
      end
    end else begin
      reg_rdata_out <= '0;
    end
  end

  flash_status_poller u_poller (
    .clk            (clk_in),
    .rst_n          (rst_n),
    .start          (poll_start_q),
    .use_sector_bit (sector_sel_q),
    .rd_done        (cyc.done),
    .rd_data        (cyc.rdata),
    .rd_req         (poll_rd_req),
    .fin            (poll_fin),
    .result         (poll_result),
    .last_status    (poll_status)
  );

  flash_pin_cycle u_cycle (
    .clk     (clk_in),
    .rst_n   (rst_n),
    .cyc     (cyc),
    .ce_n_q  (flash_ce_n_out),
    .oe_n_q  (flash_oe_n_out),
    .we_n_q  (flash_we_n_out),
    .addr_q  (flash_addr_out),
    .dq_o_q  (flash_dq_out),
    .dq_oe_q (flash_dq_oe_out),
    .hv_id_q (elevated_id_voltage_addr_out),
    .hv_oe_q (elevated_id_voltage_oe_out),
    .dq_in   (flash_dq_in)
  );

  // elevated oe voltage only in protect or unprotect with oe released high
  property p_hv_oe_mode;
    @(posedge clk_in) disable iff (!rst_n)
      elevated_id_voltage_oe_out |-> elevated_id_voltage_addr_out && flash_oe_n_out;
  endproperty
  a_hv_oe_mode: assert property (p_hv_oe_mode) else $error("elevated oe outside protect");

  // protect strobes keep the direction pin low
  property p_protect_dir;
    @(posedge clk_in) disable iff (!rst_n)
      !flash_we_n_out && elevated_id_voltage_oe_out && cmd_q == CMD_PROTECT
      |-> !flash_addr_out[PROT_DIR_ADDR_POS];
  endproperty
  a_protect_dir: assert property (p_protect_dir) else $error("direction pin high in protect");

  // unprotect strobes keep the direction pin high
  property p_unprot_dir;
    @(posedge clk_in) disable iff (!rst_n)
      !flash_we_n_out && cmd_q == CMD_UNPROT |-> flash_addr_out[PROT_DIR_ADDR_POS];
  endproperty
  a_unprot_dir: assert property (p_unprot_dir) else $error("direction pin low in unprotect");

  // verify reads drive id select high
  property p_verify_sel;
    @(posedge clk_in) disable iff (!rst_n)
      !flash_oe_n_out && cmd_q == CMD_VERIFY |-> flash_addr_out[ID_SEL_ADDR_POS];
  endproperty
  a_verify_sel: assert property (p_verify_sel) else $error("id select low in verify");

  // a poll start only happens while busy is set
  property p_poll_busy;
    @(posedge clk_in) disable iff (!rst_n) poll_start_q |-> busy_q;
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("poll without busy");

  // reads answer one cycle after the strobe and are zero otherwise
  property p_rdata_idle;
    @(posedge clk_in) disable iff (!rst_n) !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

  // a write refused for want of the reset code flags an error and starts no cycle
  property p_reset_first;
    @(posedge clk_in) disable iff (!rst_n) ctrl_wr && refuse_wr |=> err_q && !cyc_req_q;
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("write before reset code");
endmodule
`default_nettype wire

// ===== design/flash_host_pkg.sv
// constants and types for the parallel flash host controller
// assumes a 250 MHz single clock; pin timing is built from whole cycles
package flash_host_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  // strobe timing in ns, counts rounded up
  localparam int unsigned STROBE_LOW_NS   = 60;
  localparam int unsigned STROBE_HIGH_NS  = 30;
  localparam int unsigned READ_ACCESS_NS  = 130;
  localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W         = 8;

  // register offsets of the controller's own register file
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA  = 4'h4;

  // command codes written to the control register
  localparam logic [2:0] CMD_WRITE    = 3'h1;
  localparam logic [2:0] CMD_READ     = 3'h2;
  localparam logic [2:0] CMD_POLL     = 3'h3;
  localparam logic [2:0] CMD_PROTECT  = 3'h4;
  localparam logic [2:0] CMD_UNPROT   = 3'h5;
  localparam logic [2:0] CMD_VERIFY   = 3'h6;

  // reset command byte sent after a failed operation; arbitrary value, set to the part in use
  localparam logic [7:0] RESET_CMD_CODE = 8'hff;

  // status byte bit positions on the flash data bus, then control bit positions on the flash address bus
  localparam int unsigned POLLING_BIT_POS     = 7;
  localparam int unsigned BUSY_TOGGLE_POS     = 6;
  localparam int unsigned TIMING_LIMIT_POS    = 5;
  localparam int unsigned ERASE_WINDOW_POS    = 3;
  localparam int unsigned SECTOR_TOGGLE_POS   = 2;
  localparam int unsigned PROTECT_BIT_POS     = 0;
  localparam int unsigned HV_ID_ADDR_POS      = 9;
  localparam int unsigned PROT_DIR_ADDR_POS   = 6;
  localparam int unsigned ID_SEL_ADDR_POS     = 1;

  // poll result codes
  localparam logic [1:0] POLL_DONE   = 2'h1;
  localparam logic [1:0] POLL_FAILED = 2'h2;

  typedef enum logic [4:0] {
    CYC_IDLE  = 5'b00001,
    CYC_SETUP = 5'b00010,
    CYC_LOW   = 5'b00100,
    CYC_HIGH  = 5'b01000,
    CYC_DONE  = 5'b10000
  } cycle_state_t;

  typedef enum logic [5:0] {
    PL_IDLE   = 6'b000001,
    PL_FIRST  = 6'b000010,
    PL_SECOND = 6'b000100,
    PL_THIRD  = 6'b001000,
    PL_FOURTH = 6'b010000,
    PL_END    = 6'b100000
  } poll_state_t;
endpackage

// ===== design/flash_cycle_if.sv
// request and answer between the controller and its pin cycle engine
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface flash_cycle_if;
  logic        req;
  logic        is_write;
  logic        hv_mode;
  logic        hv_oe;
  logic [18:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctrl (output req, is_write, hv_mode, hv_oe, addr, wdata, input done, rdata);
  modport engine (input req, is_write, hv_mode, hv_oe, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

// ===== design/flash_pin_cycle.sv
// one read, write or high-voltage strobe cycle on the flash pins
// assumes the data pins are sampled synchronously at the end of access
`timescale 1ns/100ps
`default_nettype none
module flash_pin_cycle
  import flash_host_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  flash_cycle_if.engine        cyc,
  output logic                 ce_n_q,
  output logic                 oe_n_q,
  output logic                 we_n_q,
  output logic [18:0]          addr_q,
  output logic [7:0]           dq_o_q,
  output logic                 dq_oe_q,
  output logic                 hv_id_q,
  output logic                 hv_oe_q,
  input  wire logic [7:0]      dq_in
);
  cycle_state_t       state_q;
  logic [TIMER_W-1:0] timer_q;
  logic               wr_q;
  logic [7:0]         rdata_q;
  logic               done_q;

  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;

  // cycle sequencer; oe stays high over any write so the write is not inhibited
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CYC_IDLE;
      timer_q <= '0;
      wr_q    <= 1'b0;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      addr_q  <= '0;
      dq_o_q  <= '0;
      dq_oe_q <= 1'b0;
      hv_id_q <= 1'b0;
      hv_oe_q <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        CYC_IDLE: begin
          if (cyc.req) begin
            wr_q    <= cyc.is_write;
            addr_q  <= cyc.addr;
            dq_o_q  <= cyc.wdata;
            hv_id_q <= cyc.hv_mode;
            hv_oe_q <= cyc.hv_oe;
            ce_n_q  <= 1'b0;
            timer_q <= TIMER_W'(STROBE_HIGH_CYC);
            state_q <= CYC_SETUP;
          end
        end
        CYC_SETUP: begin
          if (timer_q > 1) begin
            timer_q <= timer_q - 1'b1;
          end else begin
            // write: ce and we low with oe high; read: oe low with we high
            we_n_q  <= ~wr_q;
            oe_n_q  <= wr_q;
            dq_oe_q <= wr_q;
            timer_q <= wr_q ? TIMER_W'(STROBE_LOW_CYC) : TIMER_W'(READ_ACCESS_CYC);
            state_q <= CYC_LOW;
          end
        end
        CYC_LOW: begin
          if (timer_q > 1) begin
            timer_q <= timer_q - 1'b1;
          end else begin
            rdata_q <= dq_in;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
            ce_n_q  <= 1'b1;
            timer_q <= TIMER_W'(STROBE_HIGH_CYC);
            state_q <= CYC_HIGH;
          end
        end
        CYC_HIGH: begin
          if (timer_q > 1) begin
            timer_q <= timer_q - 1'b1;
          end else begin
            dq_oe_q <= 1'b0;
            hv_id_q <= 1'b0;
            hv_oe_q <= 1'b0;
            state_q <= CYC_DONE;
          end
        end
        CYC_DONE: begin
          done_q  <= 1'b1;
          state_q <= CYC_IDLE;
        end
        default: state_q <= CYC_IDLE;
      endcase
    end
  end

  // never a write strobe while output enable is low
  property p_no_write_with_oe;
    @(posedge clk) disable iff (!rst_n) !we_n_q |-> oe_n_q;
  endproperty
  a_no_write_with_oe: assert property (p_no_write_with_oe) else $error("we low with oe low");

  // a write pulse stays low for at least 8 cycles
  property p_write_width;
    @(posedge clk) disable iff (!rst_n) $fell(we_n_q) |-> !we_n_q [*8];
  endproperty
  a_write_width: assert property (p_write_width) else $error("write pulse too short");
endmodule
`default_nettype wire

// ===== design/flash_status_poller.sv
// toggle status poller: double read, timing flag check, final recheck
// assumes the cycle engine serves one read at a time
`timescale 1ns/100ps
`default_nettype none
module flash_status_poller
  import flash_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        use_sector_bit,
  input  wire logic        rd_done,
  input  wire logic [7:0]  rd_data,
  output logic             rd_req,
  output logic             fin,
  output logic [1:0]       result,
  output logic [7:0]       last_status
);
  poll_state_t state_q;
  logic        prev_q;
  logic        bit_now;

  // pick the toggle bit under watch
  always_comb begin
    bit_now = use_sector_bit ? rd_data[SECTOR_TOGGLE_POS] : rd_data[BUSY_TOGGLE_POS];
  end

  // poll algorithm; a fresh start always begins with the first double read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= PL_IDLE;
      prev_q      <= 1'b0;
      rd_req      <= 1'b0;
      fin         <= 1'b0;
      result      <= '0;
      last_status <= '0;
    end else begin
      rd_req <= 1'b0;
      fin    <= 1'b0;
      case (state_q)
        PL_IDLE: begin
          if (start) begin
            rd_req  <= 1'b1;
            state_q <= PL_FIRST;
          end
        end
        PL_FIRST: begin
          if (rd_done) begin
            prev_q  <= bit_now;
            rd_req  <= 1'b1;
            state_q <= PL_SECOND;
          end
        end
        PL_SECOND: begin
          if (rd_done) begin
            last_status <= rd_data;
            prev_q      <= bit_now;
            if (bit_now == prev_q) begin
              result  <= POLL_DONE;
              state_q <= PL_END;
            end else if (rd_data[TIMING_LIMIT_POS]) begin
              rd_req  <= 1'b1;
              state_q <= PL_THIRD;
            end else begin
              rd_req  <= 1'b1;
              state_q <= PL_FIRST;
            end
          end
        end
        PL_THIRD: begin
          if (rd_done) begin
            prev_q  <= bit_now;
            rd_req  <= 1'b1;
            state_q <= PL_FOURTH;
          end
        end
        PL_FOURTH: begin
          if (rd_done) begin
            last_status <= rd_data;
            result      <= (bit_now == prev_q) ? POLL_DONE : POLL_FAILED;
            state_q     <= PL_END;
          end
        end
        PL_END: begin
          fin     <= 1'b1;
          state_q <= PL_IDLE;
        end
        default: state_q <= PL_IDLE;
      endcase
    end
  end

  // finish always follows the end state by one cycle
  property p_fin_after_end;
    @(posedge clk) disable iff (!rst_n) (state_q == PL_END) |=> fin;
  endproperty
  a_fin_after_end: assert property (p_fin_after_end) else $error("no finish pulse");

  // a failure verdict is only reached through the recheck
  property p_fail_path;
    @(posedge clk) disable iff (!rst_n) $rose(fin) && result == POLL_FAILED |-> $past(state_q, 2) == PL_FOURTH;
  endproperty
  a_fail_path: assert property (p_fail_path) else $error("failure without recheck");
endmodule
`default_nettype wire

// ===== bench/flash_dev_model.sv
// behavioural flash device: status toggles, timing flag, sector protect
// assumes strobes come from the host controller; no clock of its own
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model (
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [7:0]  dq_in,
  input  wire logic        hv_addr_in,
  input  wire logic        hv_oe_in,
  input  wire logic        stuck_in,
  output logic [7:0]       dq_out
);
  int          busy_left = 0;
  logic        busy_tgl  = 1'b0;
  logic        sect_tgl  = 1'b0;
  logic        prot      = 1'b0;
  logic [7:0]  last      = 8'h00;
  logic [18:0] wr_addr   = '0;
  logic [7:0]  wr_data   = '0;
  logic [7:0]  rd_byte;
  logic        armed     = 1'b0;
  logic        win;
  // erase window flag: high while the internal operation runs
  assign win = busy_left > 0;
  // verify code or status byte
  always_comb begin
    if (hv_addr_in) rd_byte = addr_in[1] ? {7'h00, prot} : 8'h00;
    else rd_byte = {1'b0, busy_tgl, stuck_in, 1'b1, win, sect_tgl, 2'b00};
  end
  // toggles flip once at the edge that starts each read while busy or stuck, the sector toggle only when address bits 18:16 are 2
  always @(negedge oe_n_in) begin
    if (!ce_n_in && (busy_left > 0 || stuck_in)) begin
      busy_tgl = ~busy_tgl;
      if (addr_in[18:16] == 3'h2) sect_tgl = ~sect_tgl;
      if (busy_left > 0) busy_left = busy_left - 1;
    end
  end
  // released bus shows the inverse of the last value
  always @(posedge oe_n_in) last = rd_byte;
  // the falling write strobe arms a write only with ce low and oe high
  always @(negedge we_n_in) armed = !ce_n_in && oe_n_in;
  // write taken at the rising strobe; ce may rise in the same step, so use the armed state
  always @(posedge we_n_in) begin
    if (armed && !win) begin
      if (hv_oe_in && hv_addr_in) prot = !addr_in[6];
      else begin
        wr_addr = addr_in;
        wr_data = dq_in;
      end
    end
  end
  assign dq_out = (!ce_n_in && !oe_n_in) ? rd_byte : ~last;
endmodule
`default_nettype wire

// ===== bench/test_flash_host_ctrl.sv
// self-checking bench for the flash host controller
// assumes the behavioural device model drives the flash pins
`timescale 1ns/100ps
`default_nettype none
module test_flash_host_ctrl;
  import flash_host_pkg::*;
  logic clk_in = 1'b0, rstn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, stuck = 1'b0;
  logic [3:0]  reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out, s;
  logic ce_n, oe_n, we_n, dq_oe, hv_a, hv_o;
  logic [18:0] f_addr, a;
  logic [7:0]  f_dq, m_dq, bus, d;
  int bad_count = 0, check_count = 0, seed, n;
  logic st, sec;
  always #2 clk_in = ~clk_in;
  // data pin level from both drivers
  assign bus = dq_oe ? f_dq : m_dq;
  flash_host_ctrl u_flash_host_ctrl (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_addr_out(f_addr),
    .flash_dq_out(f_dq), .flash_dq_oe_out(dq_oe), .flash_dq_in(bus),
    .elevated_id_voltage_addr_out(hv_a), .elevated_id_voltage_oe_out(hv_o));
  flash_dev_model u_flash_dev_model (.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
    .addr_in(f_addr), .dq_in(bus), .hv_addr_in(hv_a), .hv_oe_in(hv_o),
    .stuck_in(stuck), .dq_out(m_dq));
  // register port transfers
  task automatic reg_wr(input logic [3:0] ra, input logic [31:0] wd);
    @(posedge clk_in);
    reg_addr_in <= ra; reg_wdata_in <= wd; reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] ra, output logic [31:0] rd);
    @(posedge clk_in);
    reg_addr_in <= ra; reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 rd = reg_rdata_out;
  endtask
  // issue a command and wait for busy to clear
  task automatic run(input logic [31:0] c);
    logic [31:0] t;
    int k;
    reg_wr(REG_CTRL, c);
    t = 32'h1;
    k = 0;
    while (t[0] !== 1'b0 && k < 1000) begin
      reg_rd(REG_STATUS, t);
      k++;
    end
    if (k >= 1000) begin bad_count++; $display("ERROR busy expected 0 seen 1"); end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [1:0] exp_poll(input logic stk);
    return stk ? POLL_FAILED : POLL_DONE;
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #200000;
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    seed = $urandom(32'hae8424af);
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reg_rd(REG_STATUS, s);
    chk("status_reset", 32'h0, s);
    $display("test reset done");
    // polls: random toggle length, sector select, one stuck case
    for (int i = 0; i < 6; i++) begin
      st = (i == 2);
      sec = i[0];
      n = $urandom_range(0, 5);
      stuck <= st;
      u_flash_dev_model.busy_left = n;
      a = 19'($urandom_range(0, 16'hffff));
      reg_wr(REG_ADDR, {13'h0, sec ? (a | 19'h2_0000) : a});
      run({27'h0, sec, 1'b0, CMD_POLL});
      reg_rd(REG_STATUS, s);
      chk("poll_result", {30'h0, exp_poll(st)}, {30'h0, s[3:2]});
      chk("timing_flag", {31'h0, st}, {31'h0, s[13]});
      if (!st) chk("window_flag", 32'h0, {31'h0, s[11]});
      $display("test poll %0d done", i);
    end
    stuck <= 1'b0;
    // after the failed poll a write waits for the reset code, then random write, refused command
    a = 19'($urandom_range(0, 19'h7_ffff));
    d = 8'($urandom_range(0, 8'hfe));
    reg_wr(REG_ADDR, {13'h0, a});
    reg_wr(REG_WDATA, {24'h0, d});
    run({29'h0, CMD_WRITE});
    reg_rd(REG_STATUS, s);
    chk("reset_first", 32'h1, {31'h0, s[1]});
    reg_wr(REG_WDATA, {24'h0, RESET_CMD_CODE});
    run({29'h0, CMD_WRITE});
    chk("reset_code", {24'h0, RESET_CMD_CODE}, {24'h0, u_flash_dev_model.wr_data});
    reg_wr(REG_WDATA, {24'h0, d});
    run({29'h0, CMD_WRITE});
    chk("write_addr", {13'h0, a}, {13'h0, u_flash_dev_model.wr_addr});
    chk("write_data", {24'h0, d}, {24'h0, u_flash_dev_model.wr_data});
    reg_wr(REG_CTRL, {29'h0, CMD_READ});
    run({29'h0, CMD_READ});
    reg_rd(REG_STATUS, s);
    chk("err_flag", 32'h1, {31'h0, s[1]});
    $display("test write done");
    // protect, verify, unprotect, verify
    run({29'h0, CMD_PROTECT});
    run({29'h0, CMD_VERIFY});
    reg_rd(REG_RDATA, s);
    chk("verify_protected", 32'h1, s);
    run({29'h0, CMD_UNPROT});
    reg_rd(REG_STATUS, s);
    chk("unprot_flag", 32'h1, {31'h0, s[4]});
    run({29'h0, CMD_VERIFY});
    reg_rd(REG_RDATA, s);
    chk("verify_clear", 32'h0, s);
    $display("test protect done");
    results();
  end
endmodule
`default_nettype wire
